/* File: dmr_host_model.sv */
// Purpose: far-side model making the master clock, frame clock and sample strobe
// Assumes: master clock period of four system cycles, ratio_i master edges a frame
// Notes:   with run_i low both clocks stand still, as a lost clock source would
`timescale 1ns/100ps
module dmr_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        run_i,
  input  wire logic [11:0] ratio_i,
  output logic             mclk_o,
  output logic             lrck_o,
  output logic             frame_o
);
  logic [1:0]  div_q;
  logic [11:0] cnt_q;

  // master clock from the divider msb, so it stays under half the system rate
  assign mclk_o = div_q[1];

  // frames counted in master rising edges; frame_o marks each frame's samples
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q   <= 2'h0;
      cnt_q   <= 12'h0;
      lrck_o  <= 1'b0;
      frame_o <= 1'b0;
    end else begin
      frame_o <= 1'b0;
      if (run_i) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h1) begin
          if (cnt_q >= ratio_i - 12'h1) begin // >= so a shorter ratio takes hold at once
            cnt_q   <= 12'h0;
            lrck_o  <= 1'b1;
            frame_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 12'h1;
          end
          if (cnt_q == (ratio_i >> 1)) begin
            lrck_o <= 1'b0;
          end
        end
      end
    end
  end
endmodule

/* File: dmr_mute_ctrl.sv */
// Overview of operation
// - reset low puts device in low power
// - reset low returns all registers to defaults
// - control port ignores accesses during reset
// - reset high makes port and converter operational
// - mute low during init, power-down, reset
// - mute low on missing mclk or bad ratio
// - software bit asserts or releases mute
// - 512 all-channel zero samples assert mute
// - one non-zero sample releases auto mute
// - enable bit switches mute-on-zero detection
//
// Purpose: reset handling and mute-control output for a six-channel dac
// Assumes: mclk and frame clock arrive as synchronous levels on clk_sys_i
// Notes:   software bits come from the control port register file
`timescale 1ns/100ps
module dmr_mute_ctrl #(
  parameter int unsigned NCH       = dmr_pkg::NUM_CH,
  parameter int unsigned SW        = dmr_pkg::SAMPLE_W,
  parameter int unsigned ZRUN      = dmr_pkg::ZERO_RUN,
  parameter int unsigned INIT_CYCS = dmr_pkg::INIT_CYC,
  parameter int unsigned RMIN      = dmr_pkg::RATIO_MIN,
  parameter int unsigned RMAX      = dmr_pkg::RATIO_MAX,
  parameter int unsigned MCLK_TO   = dmr_pkg::MCLK_TIMEOUT
) (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  input  wire logic              power_down_i,
  input  wire logic              mclk_i,
  input  wire logic              lrck_i,
  input  wire logic              port_wr_i,
  input  wire logic              sw_mute_i,
  input  wire logic              mute_on_zero_enable_i,
  input  wire logic              sample_vld_i,
  input  wire logic [NCH*SW-1:0] samples_i,
  output logic                   low_power_o,
  output logic                   port_ready_o,
  output logic                   codec_run_o,
  output logic                   mute_control_out_o
);
  localparam int unsigned IW = $clog2(INIT_CYCS + 1);
  localparam int unsigned RW = $clog2(RMAX + 2);
  localparam int unsigned TW = $clog2(MCLK_TO + 1);
  // elaboration check on parameter values the counters cannot serve
  if (RMIN >= RMAX || INIT_CYCS < 1 || MCLK_TO < 2) begin : g_bad_param
    $error("mute control parameters unsupported");
  end

  dmr_pkg::dmr_state_t state_q;
  logic [IW-1:0] init_cnt_q;
  logic          sw_mute_q;
  logic          mutz_en_q;
  logic          mclk_q;
  logic          lrck_q;
  logic [TW-1:0] mclk_to_q;
  logic [RW-1:0] ratio_cnt_q;
  logic          ratio_ok_q;
  logic          zero_mute;
  logic          mclk_edge;
  logic          lrck_edge;
  logic          hw_cause;

  assign mclk_edge = mclk_i & ~mclk_q;
  assign lrck_edge = lrck_i & ~lrck_q;

  // power-up sequencing; reset forces init and low power
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q    <= dmr_pkg::DMR_INIT;
      init_cnt_q <= '0;
    end else if (ce_i) begin
      case (state_q)
        dmr_pkg::DMR_INIT: begin
          if (power_down_i) state_q <= dmr_pkg::DMR_DOWN;
          else if (init_cnt_q == IW'(INIT_CYCS - 1)) state_q <= dmr_pkg::DMR_RUN;
          else init_cnt_q <= init_cnt_q + IW'(1);
        end
        dmr_pkg::DMR_RUN: begin
          if (power_down_i) state_q <= dmr_pkg::DMR_DOWN;
        end
        dmr_pkg::DMR_DOWN: begin
          if (!power_down_i) begin
            state_q    <= dmr_pkg::DMR_INIT;
            init_cnt_q <= '0;
          end
        end
        default: state_q <= dmr_pkg::DMR_INIT;
      endcase
    end
  end

  // control port registers accept writes only out of reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_mute_q <= dmr_pkg::SW_MUTE_RST;
      mutz_en_q <= dmr_pkg::MUTZ_EN_RST;
    end else if (ce_i && port_wr_i) begin
      sw_mute_q <= sw_mute_i;
      mutz_en_q <= mute_on_zero_enable_i;
    end
  end

  // master clock presence watchdog
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mclk_q    <= 1'b0;
      mclk_to_q <= TW'(MCLK_TO);
    end else if (ce_i) begin
      mclk_q <= mclk_i;
      if (mclk_edge) mclk_to_q <= '0;
      else if (mclk_to_q != TW'(MCLK_TO)) mclk_to_q <= mclk_to_q + TW'(1);
    end
  end

  // mclk edges per frame, checked at each frame edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lrck_q      <= 1'b0;
      ratio_cnt_q <= '0;
      ratio_ok_q  <= 1'b0;
    end else if (ce_i) begin
      lrck_q <= lrck_i;
      if (lrck_edge) begin
        ratio_ok_q  <= (ratio_cnt_q >= RW'(RMIN)) && (ratio_cnt_q <= RW'(RMAX));
        ratio_cnt_q <= mclk_edge ? RW'(1) : '0;
      end else if (mclk_edge && ratio_cnt_q != RW'(RMAX + 1)) begin
        ratio_cnt_q <= ratio_cnt_q + RW'(1);
      end
    end
  end

  dmr_zero_det #(
    .NCH (NCH),
    .SW  (SW),
    .RUN (ZRUN)
  ) u_zero (
    .clk_sys_i    (clk_sys_i),
    .arst_n_i     (arst_n_i),
    .ce_i         (ce_i),
    .enable_i     (mutz_en_q),
    .sample_vld_i (sample_vld_i),
    .samples_i    (samples_i),
    .zero_mute_o  (zero_mute)
  );

  assign hw_cause = (state_q != dmr_pkg::DMR_RUN) || (mclk_to_q == TW'(MCLK_TO))
                    || !ratio_ok_q;

  // one decode of the mute causes, shared by the output and its checks
  function automatic logic any_cause(input logic hw, input logic sw, input logic zm);
    return hw || sw || zm;
  endfunction

  // registered outputs; mute active low
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_power_o        <= 1'b1;
      port_ready_o       <= 1'b0;
      codec_run_o        <= 1'b0;
      mute_control_out_o <= 1'b0;
    end else if (ce_i) begin
      low_power_o        <= (state_q == dmr_pkg::DMR_DOWN);
      port_ready_o       <= 1'b1;
      codec_run_o        <= (state_q == dmr_pkg::DMR_RUN);
      mute_control_out_o <= !any_cause(hw_cause, sw_mute_q, zero_mute);
    end
  end

  // checks on the mute causes and the output they drive
  mute_cause_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && any_cause(hw_cause, sw_mute_q, zero_mute) |=> !mute_control_out_o)
    else $error("mute released while a cause is present");
  mute_clear_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && !any_cause(hw_cause, sw_mute_q, zero_mute) |=> mute_control_out_o)
    else $error("mute held with no cause");
  down_mute_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && state_q == dmr_pkg::DMR_DOWN |=> !mute_control_out_o && low_power_o)
    else $error("power-down did not mute");
  mclk_lost_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && mclk_to_q == TW'(MCLK_TO) |=> !mute_control_out_o)
    else $error("missing master clock did not mute");
  ratio_bad_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && !ratio_ok_q |=> !mute_control_out_o)
    else $error("bad clock ratio did not mute");
  sw_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && port_wr_i |=> sw_mute_q == $past(sw_mute_i) && mutz_en_q == $past(mute_on_zero_enable_i))
    else $error("control bit write lost");
  sw_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && !port_wr_i |=> $stable(sw_mute_q) && $stable(mutz_en_q))
    else $error("control bits changed without a write");

  // checks on reset exit: defaults still held, mute kept low into init
  init_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(arst_n_i) |-> (!mute_control_out_o && !codec_run_o) ##1 !mute_control_out_o)
    else $error("mute released right at reset exit");
  reset_exit_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(arst_n_i) |-> low_power_o && !port_ready_o)
    else $error("reset did not hold low power");
  port_clean_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(arst_n_i) |-> sw_mute_q == dmr_pkg::SW_MUTE_RST
                        && mutz_en_q == dmr_pkg::MUTZ_EN_RST)
    else $error("control bits not at default after reset");

  // checks on sequencing and clock supervision
  init_mute_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && state_q == dmr_pkg::DMR_INIT |=> !mute_control_out_o)
    else $error("mute released during init");
  release_run_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && state_q == dmr_pkg::DMR_INIT && !power_down_i
    && init_cnt_q == IW'(INIT_CYCS - 1) |=> state_q == dmr_pkg::DMR_RUN)
    else $error("init did not end in run");
  run_out_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && state_q == dmr_pkg::DMR_RUN |=> codec_run_o && port_ready_o && !low_power_o)
    else $error("converter not operational in run");
  lp_only_down_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && state_q != dmr_pkg::DMR_DOWN |=> !low_power_o)
    else $error("low power outside power-down");
  mclk_seen_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && mclk_edge |=> mclk_to_q == '0)
    else $error("master clock edge did not restart watchdog");
  ratio_meas_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && lrck_edge && (ratio_cnt_q < RW'(RMIN) || ratio_cnt_q > RW'(RMAX))
    |=> !ratio_ok_q)
    else $error("out-of-range frame ratio accepted");
endmodule

/* File: dmr_pkg.sv */
// Purpose: shared constants for the mute and reset control block
// Assumes: one system clock, asynchronous active-low reset
// Notes:   counts are in clock cycles or frame samples
package dmr_pkg;
  localparam int unsigned NUM_CH        = 6;    // dac input channels
  localparam int unsigned SAMPLE_W      = 24;   // sample width
  localparam int unsigned ZERO_RUN      = 512;  // zero samples before auto mute
  localparam int unsigned INIT_NS       = 1000; // power-up init hold time
  localparam int unsigned CLK_NS        = 10;   // system clock period
  localparam int unsigned INIT_CYC      = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RATIO_MIN     = 128;  // least valid mclk per frame
  localparam int unsigned RATIO_MAX     = 1536; // largest valid mclk per frame
  localparam int unsigned MCLK_TIMEOUT  = 64;   // sys cycles without mclk edge
  localparam logic        SW_MUTE_RST   = 1'b0; // software mute released
  localparam logic        MUTZ_EN_RST   = 1'b0; // mute on zero off
  typedef enum logic [1:0] {
    DMR_INIT = 2'b00,
    DMR_RUN  = 2'b01,
    DMR_DOWN = 2'b11
  } dmr_state_t;
endpackage

/* File: dmr_zero_det.sv */
// Purpose: counts consecutive all-channel zero frames for auto mute
// Assumes: sample_vld_i pulses once per frame with all channels valid
// Notes:   any non-zero sample clears the run at once
`timescale 1ns/100ps
module dmr_zero_det #(
  parameter int unsigned NCH   = 6,
  parameter int unsigned SW    = 24,
  parameter int unsigned RUN   = 512
) (
  input  wire logic                clk_sys_i,
  input  wire logic                arst_n_i,
  input  wire logic                ce_i,
  input  wire logic                enable_i,
  input  wire logic                sample_vld_i,
  input  wire logic [NCH*SW-1:0]   samples_i,
  output logic                     zero_mute_o
);
  localparam int unsigned CW = $clog2(RUN + 1);
  // elaboration check: the run counter needs at least two frames to count
  if (NCH < 1 || RUN < 2) begin : g_bad_param
    $error("zero detector parameters unsupported");
  end

  logic [CW-1:0] run_q;
  logic          all_zero;
  logic [NCH-1:0] ch_zero;

  // per-channel zero flags
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign ch_zero[g] = (samples_i[g*SW +: SW] == '0);
    end
  endgenerate
  assign all_zero = &ch_zero;

  // run counter and sticky zero mute
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q       <= '0;
      zero_mute_o <= 1'b0;
    end else if (ce_i) begin
      if (!enable_i) begin
        run_q       <= '0;
        zero_mute_o <= 1'b0;
      end else if (sample_vld_i) begin
        if (!all_zero) begin
          run_q       <= '0;
          zero_mute_o <= 1'b0;
        end else if (run_q < CW'(RUN)) begin
          run_q       <= run_q + CW'(1);
          if (run_q == CW'(RUN - 1)) zero_mute_o <= 1'b1;
        end
      end
    end
  end

  zero_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && enable_i && sample_vld_i && all_zero && run_q == CW'(RUN - 1) |=> zero_mute_o)
    else $error("auto mute missed after zero run");
  zero_rel_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && sample_vld_i && !all_zero |=> !zero_mute_o && run_q == '0)
    else $error("auto mute not released on non-zero sample");
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the mute and reset control block
// Assumes: shortened init and zero-run counts, host model supplies clocks
// Notes:   samples change 1 ns after each rising edge from an xorshift source
`timescale 1ns/100ps
module tb;
  localparam int unsigned ZR = 4;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, power_down_i = 1'b0, port_wr_i = 1'b0;
  logic sw_mute_i = 1'b0, mz_en = 1'b0, run = 1'b1, mclk, lrck, frame;
  logic low_power, port_ready, codec_run, mute, b;
  logic [11:0]  ratio = 12'd160;
  logic [143:0] samples = '0;
  logic [31:0]  seed = 32'h0316;
  int err_total = 0, checks_done = 0, mode = 0, ch = 0;

  dmr_host_model host (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .run_i(run),
    .ratio_i(ratio), .mclk_o(mclk), .lrck_o(lrck), .frame_o(frame));
  dmr_mute_ctrl #(.ZRUN(ZR), .INIT_CYCS(4)) uut (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .ce_i(1'b1), .power_down_i(power_down_i), .mclk_i(mclk),
    .lrck_i(lrck), .port_wr_i(port_wr_i), .sw_mute_i(sw_mute_i),
    .mute_on_zero_enable_i(mz_en), .sample_vld_i(frame), .samples_i(samples),
    .low_power_o(low_power), .port_ready_o(port_ready), .codec_run_o(codec_run),
    .mute_control_out_o(mute));

  // clock generator
  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // mute pin is high only when the core runs and no mute cause is present
  function automatic logic exp_mute(input logic ok, input logic sw, input logic zm);
    return ok && !sw && !zm;
  endfunction

  // sample source: random non-zero, all zero, or one non-zero channel
  always @(posedge clk_sys_i) begin
    #1;
    seed = xs(seed);
    case (mode)
      0: samples = {6{seed[23:0] | 24'h1}};
      1: samples = '0;
      default: samples = 144'(seed[23:0] | 24'h1) << (24 * ch);
    endcase
  end

  task automatic wc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wf(input int n);
    repeat (n) @(posedge clk_sys_i iff frame);
    #1;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic sw, input logic mz);
    port_wr_i = 1'b1;
    sw_mute_i = sw;
    mz_en = mz;
    wc(1);
    port_wr_i = 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // main sequence
  initial begin
    wc(10);
    chk(low_power, 1'b1, "low power in reset");
    chk(port_ready, 1'b0, "port closed in reset");
    chk(codec_run, 1'b0, "core idle in reset");
    chk(mute, 1'b0, "mute in reset");
    arst_n_i = 1'b1;
    wc(2);
    chk(port_ready, 1'b1, "port open");
    chk(low_power, 1'b0, "low power left");
    chk(mute, 1'b0, "mute in init");
    wc(8);
    chk(codec_run, 1'b1, "core running");
    wf(2);
    wc(2);
    chk(mute, exp_mute(1'b1, 1'b0, 1'b0), "unmuted");
    for (int i = 0; i < 6; i++) begin
      b = seed[i];
      wr(b, 1'b0);
      wc(1);
      chk(mute, exp_mute(1'b1, b, 1'b0), "software mute");
    end
    wr(1'b0, 1'b1);
    wf(1);
    mode = 1;
    wf(ZR - 1);
    wc(2);
    chk(mute, 1'b1, "zero run one short");
    wf(1);
    wc(2);
    chk(mute, 1'b0, "zero run mute");
    ch = int'(seed % 32'd6);
    mode = 2;
    wf(1);
    wc(2);
    mode = 1;
    chk(mute, 1'b1, "one non-zero sample");
    wr(1'b0, 1'b0);
    wf(ZR + 2);
    wc(2);
    chk(mute, 1'b1, "zero mute disabled");
    mode = 0;
    power_down_i = 1'b1;
    wc(3);
    chk(low_power, 1'b1, "power-down low power");
    chk(mute, 1'b0, "power-down mute");
    power_down_i = 1'b0;
    wc(10);
    wf(2);
    wc(2);
    chk(mute, 1'b1, "after power-down");
    run = 1'b0;
    wc(70);
    chk(mute, 1'b0, "master clock lost");
    run = 1'b1;
    wf(2);
    wc(2);
    chk(mute, 1'b1, "master clock back");
    ratio = 12'd64;
    wf(2);
    wc(2);
    chk(mute, 1'b0, "ratio too low");
    ratio = 12'd2000;
    wf(2);
    wc(2);
    chk(mute, 1'b0, "ratio too high");
    ratio = 12'd160;
    wf(2);
    wc(2);
    chk(mute, 1'b1, "ratio valid");
    wr(1'b1, 1'b0);
    arst_n_i = 1'b0;
    wc(1);
    chk(mute, 1'b0, "mid-run reset mute");
    chk(low_power, 1'b1, "mid-run reset low power");
    chk(port_ready, 1'b0, "mid-run reset port");
    arst_n_i = 1'b1;
    wc(10);
    wf(2);
    wc(2);
    chk(mute, 1'b1, "software mute cleared");
    tally_and_finish();
  end
endmodule
